// ==== hw/mcs_params.svh ====
// Register offsets, field positions, reset values and timing for the converter sync control block.
// Included by the package and the design; holds definitions only.
`ifndef MCS_PARAMS_SVH
`define MCS_PARAMS_SVH
`define MCS_ADDR_W 4
`define MCS_OFF_SYNC_CFG 4'hE
`define MCS_OFF_RSVD_RO 4'hF
`define MCS_SYNC_CFG_RST 16'h0003
`define MCS_RSVD_RO_VAL 16'h001D
`define MCS_DLY_MSB 15
`define MCS_DLY_LSB 7
`define MCS_DLY_W 9
`define MCS_DLY_MAX_CODE 9'h13F
`define MCS_DLY_MAX_PS 1200
`define MCS_IQ_BIT 6
`define MCS_RSV_BIT 5
`define MCS_PH_MSB 4
`define MCS_PH_LSB 3
`define MCS_SLAVE_BIT 2
`define MCS_DOC_BIT 1
`define MCS_DR_BIT 0
`define MCS_DIV4_W 2
`define MCS_DIV4_LAST 2'h3
`define MCS_DIV4_HALF 2'h2
`define MCS_REF_OUTS 2
`endif

// ==== hw/mcs_pkg.sv ====
// Types shared by the converter sync control block.
// Assumes mcs_params.svh is on the include path.
`include "mcs_params.svh"
package mcs_pkg;
   typedef enum logic [1:0] {
      MCS_PH_0 = 2'b00,
      MCS_PH_90 = 2'b01,
      MCS_PH_180 = 2'b10,
      MCS_PH_270 = 2'b11
   } mcs_phase_t;
   typedef enum logic [0:0] {
      MCS_MASTER = 1'b0,
      MCS_SLAVE = 1'b1
   } mcs_role_t;
endpackage

// ==== hw/mcs_sync_ctrl.sv ====
// Sync configuration register and the reference clock logic it steers.
// Assumes one 100 MHz clock, a plain register port, and a reference input from a peer converter pin.
// Operation
// RL1: Reference input delayed by programmable 9-bit code.
// RL2: Codes at or above 319 saturate delay.
// RL3: Dual-edge mode samples I and Q 180 apart.
// RL4: Software clears other register field for dual-edge.
// RL5: Software writes reserved bit 5 as zero.
// RL6: Phase select latches reference at chosen quarter.
// RL7: Slave aligns divided clocks to master reference.
// RL8: Disable bit low drives divide-by-four outputs.
// RL9: Output enable independent of master or slave.
// RL10: Reset-disable bit gates output clock realignment.
// RL11: Address fifteen read only, writes ignored.
// RL12: Register reads back written fields immediately after.
//
// The implementer's own choice: the strobed register port.
`include "mcs_params.svh"
module mcs_sync_ctrl #(
   parameter int DLY_W = `MCS_DLY_W
) (
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic [`MCS_ADDR_W-1:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [15:0] o_rdata,
   input wire logic i_ref_clk_in,
   input wire logic i_output_clk_realign,
   output logic o_sync_ref_out_a,
   output logic o_sync_ref_out_b,
   output logic o_sync_ref_oe_n,
   output logic [DLY_W-1:0] o_ref_clk_delay,
   output logic [1:0] o_phase_select,
   output logic o_slave_enable,
   output logic o_dual_edge_iq_mode,
   output logic o_q_sample_en,
   output logic o_i_sample_en,
   output logic o_ref_latched,
   output logic o_div_realign
);
   logic [15:0] cfg_r;
   logic [DLY_W-1:0] dly_sat;
   logic [1:0] ref_sync_r;
   logic [1:0] rlg_sync_r;
   logic [`MCS_DIV4_W-1:0] div_r;
   logic [`MCS_DIV4_W-1:0] div_nxt;
   logic [`MCS_REF_OUTS-1:0] ref_out_r;
   logic ref_prev_r;
   logic rlg_prev_r;
   logic ref_rise;
   logic realign_go;
   logic [1:0] ph_sel;
   logic div_free;
   mcs_pkg::mcs_role_t role;

   // Configuration register; address fifteen has no storage.
   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         cfg_r <= `MCS_SYNC_CFG_RST;
      end else if (i_wr && i_addr == `MCS_OFF_SYNC_CFG) begin
         cfg_r <= i_wdata; // RL12 RL11
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         o_rdata <= 16'h0000;
      end else if (i_rd) begin
         case (i_addr)
            `MCS_OFF_SYNC_CFG: o_rdata <= cfg_r; // RL12
            `MCS_OFF_RSVD_RO: o_rdata <= `MCS_RSVD_RO_VAL; // RL11
            default: o_rdata <= 16'h0000;
         endcase
      end else begin
         o_rdata <= 16'h0000;
      end
   end

   // Delay code as applied by the analog delay line, saturated at its maximum.
   always_comb begin
      dly_sat = cfg_r[`MCS_DLY_MSB:`MCS_DLY_LSB]; // RL1
      if (cfg_r[`MCS_DLY_MSB:`MCS_DLY_LSB] >= `MCS_DLY_MAX_CODE) begin
         dly_sat = `MCS_DLY_MAX_CODE; // RL2
      end
   end

   assign ph_sel = cfg_r[`MCS_PH_MSB:`MCS_PH_LSB];
   assign role = mcs_pkg::mcs_role_t'(cfg_r[`MCS_SLAVE_BIT]);

   // Two-flop synchronisers for the peer reference and the realign pin.
   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         ref_sync_r <= 2'h0;
      end else begin
         ref_sync_r <= {ref_sync_r[0], i_ref_clk_in};
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         rlg_sync_r <= 2'h0;
      end else begin
         rlg_sync_r <= {rlg_sync_r[0], i_output_clk_realign};
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         ref_prev_r <= 1'h0;
      end else begin
         ref_prev_r <= ref_sync_r[1];
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         rlg_prev_r <= 1'h0;
      end else begin
         rlg_prev_r <= rlg_sync_r[1];
      end
   end

   assign ref_rise = ref_sync_r[1] && !ref_prev_r;
   assign realign_go = rlg_sync_r[1] && !rlg_prev_r && !cfg_r[`MCS_DR_BIT]; // RL10

   // Divide-by-four counter; a slave restarts it on each rising master reference edge.
   always_comb begin
      div_nxt = div_r + `MCS_DIV4_W'(1);
      if ((role == mcs_pkg::MCS_SLAVE && ref_rise) || realign_go) begin
         div_nxt = '0; // RL7 RL10
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         div_r <= '0;
      end else begin
         div_r <= div_nxt;
      end
   end

   // Reference sampled at the quarter of the divided period chosen by the phase field.
   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         o_ref_latched <= 1'h0;
      end else if (div_r == ph_sel) begin
         o_ref_latched <= ref_sync_r[1]; // RL6
      end
   end

   // Divided clock outputs; both drivers share one divider and one enable.
   assign div_free = !cfg_r[`MCS_DOC_BIT] && !cfg_r[`MCS_SLAVE_BIT] && !realign_go;

   for (genvar g = 0; g < `MCS_REF_OUTS; g++) begin : g_ref_out
      always_ff @(posedge i_clock) begin
         if (!i_nrst) begin
            ref_out_r[g] <= 1'h0;
         end else begin
            ref_out_r[g] <= !cfg_r[`MCS_DOC_BIT] && (div_nxt < `MCS_DIV4_HALF); // RL8
         end
      end
   end

   assign o_sync_ref_out_a = ref_out_r[0];
   assign o_sync_ref_out_b = ref_out_r[1];

   // The driver enable ignores the master or slave role.
   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         o_sync_ref_oe_n <= 1'h1;
      end else begin
         o_sync_ref_oe_n <= cfg_r[`MCS_DOC_BIT]; // RL8 RL9
      end
   end

   // Dual-edge strobes: I on the first half, Q half a divided period later.
   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         o_i_sample_en <= 1'b0;
         o_q_sample_en <= 1'b0;
      end else begin
         o_i_sample_en <= div_nxt == '0;
         o_q_sample_en <= cfg_r[`MCS_IQ_BIT] ? (div_nxt == `MCS_DIV4_HALF) : (div_nxt == '0); // RL3
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         o_ref_clk_delay <= '0;
      end else begin
         o_ref_clk_delay <= dly_sat; // RL1 RL2
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         o_phase_select <= 2'h0;
      end else begin
         o_phase_select <= ph_sel; // RL6
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         o_slave_enable <= 1'h0;
      end else begin
         o_slave_enable <= cfg_r[`MCS_SLAVE_BIT]; // RL7
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         o_dual_edge_iq_mode <= 1'h0;
      end else begin
         o_dual_edge_iq_mode <= cfg_r[`MCS_IQ_BIT]; // RL3
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         o_div_realign <= 1'h0;
      end else begin
         o_div_realign <= realign_go; // RL10
      end
   end

   // Checks on the register file and on the controls that it drives.
   property p_sat;
      @(posedge i_clock) disable iff (!i_nrst)
         cfg_r[`MCS_DLY_MSB:`MCS_DLY_LSB] >= `MCS_DLY_MAX_CODE |=> o_ref_clk_delay == `MCS_DLY_MAX_CODE;
   endproperty
   a_sat: assert property (p_sat) else $error("Delay code not saturated."); // RL2

   property p_dly;
      @(posedge i_clock) disable iff (!i_nrst)
         cfg_r[`MCS_DLY_MSB:`MCS_DLY_LSB] < `MCS_DLY_MAX_CODE |=>
            o_ref_clk_delay == $past(cfg_r[`MCS_DLY_MSB:`MCS_DLY_LSB]);
   endproperty
   a_dly: assert property (p_dly) else $error("Delay code not passed through."); // RL1

   property p_wr;
      @(posedge i_clock) disable iff (!i_nrst)
         i_wr && i_addr == `MCS_OFF_SYNC_CFG ##1 i_rd && i_addr == `MCS_OFF_SYNC_CFG |=>
            o_rdata == $past(i_wdata, 2);
   endproperty
   a_wr: assert property (p_wr) else $error("Readback differs from write."); // RL12

   property p_ro;
      @(posedge i_clock) disable iff (!i_nrst)
         i_rd && i_addr == `MCS_OFF_RSVD_RO |=> o_rdata == `MCS_RSVD_RO_VAL;
   endproperty
   a_ro: assert property (p_ro) else $error("Read-only word changed."); // RL11

   property p_off;
      @(posedge i_clock) disable iff (!i_nrst)
         cfg_r[`MCS_DOC_BIT] ##1 cfg_r[`MCS_DOC_BIT] |-> o_sync_ref_oe_n && !o_sync_ref_out_a && !o_sync_ref_out_b;
   endproperty
   a_off: assert property (p_off) else $error("Reference outputs driven while disabled."); // RL8

   property p_div4;
      @(posedge i_clock) disable iff (!i_nrst)
         !cfg_r[`MCS_DOC_BIT] ##1 div_free ##1 (div_free && $rose(o_sync_ref_out_a)) ##1 div_free |->
            o_sync_ref_out_a ##1 !o_sync_ref_out_a;
   endproperty
   a_div4: assert property (p_div4) else $error("Reference output not divide by four."); // RL8 RL9

   property p_slave;
      @(posedge i_clock) disable iff (!i_nrst)
         role == mcs_pkg::MCS_SLAVE && ref_rise |=> div_r == '0;
   endproperty
   a_slave: assert property (p_slave) else $error("Slave did not align to reference."); // RL7

   property p_rlg;
      @(posedge i_clock) disable iff (!i_nrst)
         cfg_r[`MCS_DR_BIT] |=> !o_div_realign;
   endproperty
   a_rlg: assert property (p_rlg) else $error("Realign honoured while disabled."); // RL10

   property p_iq;
      @(posedge i_clock) disable iff (!i_nrst)
         o_i_sample_en && cfg_r[`MCS_IQ_BIT] && $stable(cfg_r) |-> !o_q_sample_en;
   endproperty
   a_iq: assert property (p_iq) else $error("Q strobe not offset in dual-edge mode."); // RL3

   property p_ph;
      @(posedge i_clock) disable iff (!i_nrst)
         div_r == ph_sel |=> o_ref_latched == $past(ref_sync_r[1]);
   endproperty
   a_ph: assert property (p_ph) else $error("Reference latched at wrong phase."); // RL6

   property p_cfg;
      @(posedge i_clock) disable iff (!i_nrst)
         i_wr && i_addr == `MCS_OFF_SYNC_CFG |=> cfg_r == $past(i_wdata);
   endproperty
   a_cfg: assert property (p_cfg) else $error("Write did not land in the sync register."); // RL12

   property p_ro_wr;
      @(posedge i_clock) disable iff (!i_nrst)
         i_wr && i_addr != `MCS_OFF_SYNC_CFG |=> $stable(cfg_r);
   endproperty
   a_ro_wr: assert property (p_ro_wr) else $error("Write elsewhere changed the sync register."); // RL11

   property p_rdz;
      @(posedge i_clock) disable iff (!i_nrst)
         !i_rd |=> o_rdata == 16'h0000;
   endproperty
   a_rdz: assert property (p_rdz) else $error("Read data not cleared outside a read."); // RL12

   property p_ab;
      @(posedge i_clock) disable iff (!i_nrst)
         o_sync_ref_out_a == o_sync_ref_out_b;
   endproperty
   a_ab: assert property (p_ab) else $error("Reference outputs differ."); // RL8

   property p_oe;
      @(posedge i_clock) disable iff (!i_nrst)
         1'h1 |=> o_sync_ref_oe_n == $past(cfg_r[`MCS_DOC_BIT]);
   endproperty
   a_oe: assert property (p_oe) else $error("Driver enable does not follow its bit."); // RL9

   property p_ph_out;
      @(posedge i_clock) disable iff (!i_nrst)
         1'h1 |=> o_phase_select == $past(ph_sel);
   endproperty
   a_ph_out: assert property (p_ph_out) else $error("Phase select output stale."); // RL6

   property p_slv_out;
      @(posedge i_clock) disable iff (!i_nrst)
         1'h1 |=> o_slave_enable == $past(cfg_r[`MCS_SLAVE_BIT]);
   endproperty
   a_slv_out: assert property (p_slv_out) else $error("Slave enable output stale."); // RL7

   property p_mode;
      @(posedge i_clock) disable iff (!i_nrst)
         1'h1 |=> o_dual_edge_iq_mode == $past(cfg_r[`MCS_IQ_BIT]);
   endproperty
   a_mode: assert property (p_mode) else $error("Dual-edge mode output stale."); // RL3

   property p_iq_off;
      @(posedge i_clock) disable iff (!i_nrst)
         !cfg_r[`MCS_IQ_BIT] && $stable(cfg_r) |-> o_q_sample_en == o_i_sample_en;
   endproperty
   a_iq_off: assert property (p_iq_off) else $error("Q strobe offset outside dual-edge mode."); // RL3

   property p_rlg_on;
      @(posedge i_clock) disable iff (!i_nrst)
         !cfg_r[`MCS_DR_BIT] && rlg_sync_r[1] && !rlg_prev_r |=> o_div_realign && div_r == '0;
   endproperty
   a_rlg_on: assert property (p_rlg_on) else $error("Enabled realign not honoured."); // RL10

   c_slave: cover property (@(posedge i_clock) disable iff (!i_nrst) role == mcs_pkg::MCS_SLAVE && ref_rise);
   c_out: cover property (@(posedge i_clock) disable iff (!i_nrst) !o_sync_ref_oe_n && o_sync_ref_out_a);
   c_iq: cover property (@(posedge i_clock) disable iff (!i_nrst) o_dual_edge_iq_mode && o_q_sample_en);
   c_rlg: cover property (@(posedge i_clock) disable iff (!i_nrst) o_div_realign);
   c_sat: cover property (@(posedge i_clock) disable iff (!i_nrst) o_ref_clk_delay == `MCS_DLY_MAX_CODE);
endmodule // mcs_sync_ctrl

// ==== tb/mcs_peer_model.sv ====
// Behavioural peer converter acting as master: reference clock and realign pin.
// Assumes it shares the bench clock; the reference stands low while not running.
module mcs_peer_model (
   input wire logic i_clock,
   input wire logic i_run,
   input wire logic i_realign,
   output logic o_ref_clk,
   output logic o_realign
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] div_r = 2'h0;
   initial o_ref_clk = 1'b0;
   initial o_realign = 1'b0;
   // The master reference is a divide-by-four copy of the clock.
   always @(posedge i_clock) begin
      div_r <= i_run ? div_r + 2'h1 : 2'h0;
      o_ref_clk <= i_run & div_r[1];
      o_realign <= i_realign;
   end
endmodule // mcs_peer_model

// ==== tb/mcs_sync_ctrl_tb.sv ====
// Self-checking bench for the converter sync control block.
// Assumes the design files and the peer model are compiled before it.
module mcs_sync_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clock = 1'b0, i_nrst = 1'b0, i_wr = 1'b0, i_rd = 1'b0, run = 1'b0, rlg = 1'b0;
   logic [3:0] i_addr = 4'h0;
   logic [15:0] i_wdata = 16'h0000, d, rdv;
   logic [31:0] seed = 32'h18E2DFF6;
   logic [15:0] corner [4] = '{16'h9F00, 16'h9F80, 16'hA000, 16'hFF80};
   logic ref_w, rlg_w, oa, ob, oen, mode, slv, qsmp, ismp, lat, dre;
   logic [8:0] dly;
   logic [1:0] ph;
   logic [2:0] rh = 3'h0;
   logic [15:0] o_rdata;
   int error_cnt = 0, checks_done = 0, cyc = 0, n, k;
   always #5 i_clock = ~i_clock;
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic logic [15:0] sat(input logic [15:0] v);
      return {7'h00, (v[15:7] >= 9'h13F) ? 9'h13F : v[15:7]};
   endfunction
   task chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task end_sim;
      $display("checks=%0d errors=%0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge i_clock);
      i_addr <= a;
      i_wdata <= v;
      i_wr <= 1'b1;
      @(posedge i_clock);
      i_wr <= 1'b0;
   endtask
   task rd(input logic [3:0] a);
      @(posedge i_clock);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clock);
      i_rd <= 1'b0;
      #1 rdv = o_rdata;
   endtask
   // Counts realign pulses seen over eight cycles.
   task count_dre;
      k = 0;
      repeat (8) begin
         @(posedge i_clock);
         #1 k += dre;
      end
   endtask
   always @(posedge i_clock) begin
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         end_sim();
      end
   end
   mcs_peer_model mcs_peer_model_inst (.i_clock(i_clock), .i_run(run), .i_realign(rlg), .o_ref_clk(ref_w),
      .o_realign(rlg_w));
   mcs_sync_ctrl mcs_sync_ctrl_inst (.i_clock(i_clock), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ref_clk_in(ref_w), .i_output_clk_realign(rlg_w),
      .o_sync_ref_out_a(oa), .o_sync_ref_out_b(ob), .o_sync_ref_oe_n(oen), .o_ref_clk_delay(dly),
      .o_phase_select(ph), .o_slave_enable(slv), .o_dual_edge_iq_mode(mode), .o_q_sample_en(qsmp),
      .o_i_sample_en(ismp), .o_ref_latched(lat), .o_div_realign(dre));
   initial begin
      repeat (12) @(posedge i_clock);
      i_nrst <= 1'b1;
      run <= 1'b1;
      rd(4'hE);
      chk(rdv, 16'h0003);
      chk({14'h0, oen, oa}, 16'h0002);
      wr(4'hF, 16'h5A5A);
      rd(4'hF);
      chk(rdv, 16'h001D);
      rd(4'h3);
      chk(rdv, 16'h0000);
      for (int i = 0; i < 24; i++) begin
         seed = lfsr(seed);
         d = (i < 4) ? corner[i] : seed[15:0];
         d[5] = 1'b0;
         wr(4'hE, d);
         rd(4'hE);
         chk(rdv, d);
         chk({7'h00, dly}, sat(d));
         chk({11'h0, ph, slv, mode, oen}, {11'h0, d[4:2], d[6], d[1]});
      end
      for (int s = 0; s < 2; s++) begin
         wr(4'hE, {13'h0, s[0], 2'h0});
         rd(4'hE);
         n = 0;
         for (int c = 0; c < 12; c++) begin
            @(posedge i_clock);
            #1;
            if (c >= 4) n += oa;
            chk({15'h0, ob}, {15'h0, oa});
            if (s == 1 && c >= 4) chk({15'h0, oa}, {15'h0, rh[2]});
            rh = {rh[1:0], ref_w};
         end
         chk(n[15:0], 16'h0004);
         chk({15'h0, oen}, 16'h0000);
      end
      wr(4'h0, 16'h0000);
      wr(4'hE, 16'h0043);
      rd(4'hE);
      n = 0;
      while (ismp !== 1'b1 && n < 8) begin
         @(posedge i_clock);
         #1 n++;
      end
      chk({15'h0, qsmp}, 16'h0000);
      repeat (2) @(posedge i_clock);
      #1 chk({15'h0, qsmp}, 16'h0001);
      for (int s = 0; s < 2; s++) begin
         wr(4'hE, {15'h1, s[0]});
         @(posedge i_clock);
         rlg <= 1'b1;
         count_dre();
         chk(k[15:0], {15'h0, ~s[0]});
         rlg <= 1'b0;
         repeat (4) @(posedge i_clock);
      end
      end_sim();
   end
endmodule // mcs_sync_ctrl_tb
